// [sil_led_model.sv]
// board indicator model: counts lit cycles of each indicator
// assumes indicator levels registered on sys_clk_in, high = lit
`timescale 1ns/1ps

// ************************************************************
// lit-cycle counters
// ************************************************************
module sil_led_model (
  input  wire logic            sys_clk_in,
  input  wire logic            clear_in,
  input  wire logic [2:0]      ind_in,
  output logic      [2:0][7:0] lit_out
);
  logic [2:0][7:0] lit_reg;
  logic [2:0][7:0] lit_next;

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      lit_next[i] = clear_in ? 8'h00 : lit_reg[i] + {7'h00, ind_in[i]};
    end
  end

  always_ff @(posedge sys_clk_in) begin
    lit_reg <= lit_next;
  end

  assign lit_out = lit_reg;
endmodule

// [sil_parts.sv]
// event stretcher and per-indicator source selector
// assumes sys_clk_in / rst_in of the owning top and same-domain inputs
`timescale 1ns/1ps

// ************************************************************
// stretcher: holds an event for len_in cycles, restarting
// ************************************************************
module sil_stretch
  import sil_pkg::*;
(
  input  wire logic             sys_clk_in,
  input  wire logic             rst_in,
  input  wire logic             event_in,
  input  wire logic [CNT_W-1:0] len_in,
  output logic                  held_out
);
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;

  always_comb begin
    cnt_next = cnt_reg;
    if (event_in) begin
      cnt_next = len_in;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - CNT_W'(1);
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign held_out = (cnt_reg != '0);

  property p_reload;
    @(posedge sys_clk_in) disable iff (rst_in)
      event_in |=> (cnt_reg == $past(len_in)) && held_out;
  endproperty
  a_reload: assert property (p_reload) else $error("stretch not reloaded");

  property p_countdown;
    @(posedge sys_clk_in) disable iff (rst_in)
      (!event_in && cnt_reg > CNT_W'(1)) |=> held_out;
  endproperty
  a_countdown: assert property (p_countdown) else $error("stretch cut short");
endmodule

// ************************************************************
// selector: one registered indicator per instance
// ************************************************************
module sil_channel
  import sil_pkg::*;
(
  input  wire logic     sys_clk_in,
  input  wire logic     rst_in,
  input  wire sil_sel_t sel_in,
  input  wire sil_src_t src_in,
  output logic          ind_out
);
  logic ind_reg;
  logic ind_next;

  always_comb begin
    ind_next = 1'b0;
    unique case (sel_in)
      SEL_SPEED:    ind_next = src_in.speed;
      SEL_TX:       ind_next = src_in.tx;
      SEL_RX:       ind_next = src_in.rx;
      SEL_COL:      ind_next = src_in.col;
      SEL_LINK:     ind_next = src_in.link;
      SEL_DUPLEX:   ind_next = src_in.duplex;
      SEL_UNUSED_6: ind_next = 1'b0;
      SEL_ACT:      ind_next = src_in.act;
      SEL_ON:       ind_next = 1'b1;
      SEL_OFF:      ind_next = 1'b0;
      SEL_FAST:     ind_next = src_in.blink_fast;
      SEL_SLOW:     ind_next = src_in.blink_slow;
      // events flip the solid link or duplex state, whether it is on or off
      SEL_LINK_RX:  ind_next = src_in.link ^ src_in.rx_held;
      SEL_LINK_ACT: ind_next = src_in.link ^ src_in.act_held;
      SEL_DUP_COL:  ind_next = src_in.duplex ^ src_in.col_held;
      SEL_UNUSED_F: ind_next = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      ind_reg <= 1'b0;
    end else begin
      ind_reg <= ind_next;
    end
  end

  assign ind_out = ind_reg;
endmodule

// [sil_pkg.sv]
// constants, codes and carrier types for the status indicator block
// assumes a 50 MHz device clock and event levels from the same domain
package sil_pkg;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_FREQ_KHZ    = 50000;
  localparam int STRETCH_SHORT_MS = 30;
  localparam int STRETCH_MID_MS   = 60;
  localparam int STRETCH_LONG_MS  = 100;
  localparam int BLINK_FAST_MS    = 100;
  localparam int BLINK_SLOW_MS    = 500;
  localparam int STRETCH_SHORT_CYC = STRETCH_SHORT_MS * CLK_FREQ_KHZ;
  localparam int STRETCH_MID_CYC   = STRETCH_MID_MS * CLK_FREQ_KHZ;
  localparam int STRETCH_LONG_CYC  = STRETCH_LONG_MS * CLK_FREQ_KHZ;
  localparam int BLINK_FAST_CYC    = BLINK_FAST_MS * CLK_FREQ_KHZ;
  localparam int BLINK_SLOW_CYC    = BLINK_SLOW_MS * CLK_FREQ_KHZ;
  localparam int CNT_W             = 26;

  // ************************************************************
  // register map
  // ************************************************************
  localparam int          ADDR_W        = 8;
  localparam int          DATA_W        = 32;
  localparam int          CFG_W         = 16;
  localparam logic [7:0]  CFG_OFFSET    = 8'h14;
  localparam logic [7:0]  STATUS_OFFSET = 8'h18;
  localparam logic [15:0] CFG_RESET     = 16'h0422;
  localparam int          SEL_A_LSB     = 12;
  localparam int          SEL_B_LSB     = 8;
  localparam int          SEL_C_LSB     = 4;
  localparam int          IVL_LSB       = 2;
  localparam int          STRETCH_BIT   = 1;
  localparam int          RSVD_BIT      = 0;
  localparam int          STAT_IND_LSB  = 0;
  localparam int          STAT_HELD_LSB = 4;
  localparam int          SEL_W         = 4;
  localparam int          IVL_W         = 2;
  localparam int          NUM_IND       = 3;
  localparam int          NUM_EVT       = 4;
  localparam int          EVT_TX        = 0;
  localparam int          EVT_RX        = 1;
  localparam int          EVT_COL       = 2;
  localparam int          EVT_ACT       = 3;

  // ************************************************************
  // codes and carrier
  // ************************************************************
  typedef enum logic [3:0] {
    SEL_SPEED    = 4'h0, SEL_TX       = 4'h1, SEL_RX      = 4'h2,
    SEL_COL      = 4'h3, SEL_LINK     = 4'h4, SEL_DUPLEX  = 4'h5,
    SEL_UNUSED_6 = 4'h6, SEL_ACT      = 4'h7, SEL_ON      = 4'h8,
    SEL_OFF      = 4'h9, SEL_FAST     = 4'hA, SEL_SLOW    = 4'hB,
    SEL_LINK_RX  = 4'hC, SEL_LINK_ACT = 4'hD, SEL_DUP_COL = 4'hE,
    SEL_UNUSED_F = 4'hF
  } sil_sel_t;

  typedef enum logic [1:0] {
    IVL_SHORT = 2'h0, IVL_MID = 2'h1, IVL_LONG = 2'h2, IVL_RSVD = 2'h3
  } sil_ivl_t;

  typedef struct packed {
    logic speed;
    logic link;
    logic duplex;
    logic tx;
    logic rx;
    logic col;
    logic act;
    logic rx_held;
    logic act_held;
    logic col_held;
    logic blink_fast;
    logic blink_slow;
  } sil_src_t;

endpackage

// [sil_top.sv]
// status indicator driver: config register, stretchers, blink, muxes
// assumes an Avalon-MM master on sys_clk_in and same-domain event levels
// Notes on behaviour
// - indicator A select bits 15:12, reset speed
// - codes 1,2,3 show tx, rx, collision stretched
// - codes 4,5 link/duplex; 7 activity; 6 unused
// - codes 8..B force on, off, fast, slow
// - codes C,D,E combined displays; F unused
// - link solid; receive/activity events toggle it
// - full duplex solid; collisions toggle it
// - combined displays always stretch events
// - indicator B select bits 11:8, reset link
// - interval select: 30, 60, 100 ms
// - stretch enable bit, reset one
`timescale 1ns/1ps

module sil_top
  import sil_pkg::*;
#(
  parameter int STRETCH_SHORT = STRETCH_SHORT_CYC,
  parameter int STRETCH_MID   = STRETCH_MID_CYC,
  parameter int STRETCH_LONG  = STRETCH_LONG_CYC,
  parameter int BLINK_FAST    = BLINK_FAST_CYC,
  parameter int BLINK_SLOW    = BLINK_SLOW_CYC
)(
  input  wire logic              sys_clk_in,
  input  wire logic              rst_in,
  input  wire logic [ADDR_W-1:0] avs_address_in,
  input  wire logic              avs_read_in,
  input  wire logic              avs_write_in,
  input  wire logic [DATA_W-1:0] avs_writedata_in,
  input  wire logic [3:0]        avs_byteenable_in,
  output logic      [DATA_W-1:0] avs_readdata_out,
  output logic                   avs_waitrequest_out,
  input  wire logic              speed_in,
  input  wire logic              link_in,
  input  wire logic              duplex_in,
  input  wire logic              tx_in,
  input  wire logic              rx_in,
  input  wire logic              col_in,
  output logic     [NUM_IND-1:0] indicator_out
);

  // ************************************************************
  // elaboration checks
  // ************************************************************
  initial begin
    if (STRETCH_SHORT < 4 || STRETCH_MID < 4 || STRETCH_LONG < 4 ||
        STRETCH_LONG >= (1 << CNT_W) || STRETCH_MID >= (1 << CNT_W) ||
        STRETCH_SHORT >= (1 << CNT_W)) begin
      $error("stretch length out of range");
    end
    if (BLINK_FAST < 1 || BLINK_SLOW < 1 || BLINK_SLOW >= (1 << CNT_W) ||
        BLINK_FAST >= (1 << CNT_W)) begin
      $error("blink length out of range");
    end
  end

  // ************************************************************
  // register slave
  // ************************************************************
  logic [CFG_W-1:0]  cfg_reg;
  logic [CFG_W-1:0]  cfg_next;
  logic              ack_reg;
  logic              ack_next;
  logic [DATA_W-1:0] rdata_reg;
  logic [DATA_W-1:0] rdata_next;
  logic [NUM_EVT-1:0] held;
  logic [NUM_IND-1:0] ind;
  logic              blink_fast_reg;
  logic              blink_fast_next;
  logic              blink_slow_reg;
  logic              blink_slow_next;

  function automatic logic [DATA_W-1:0] read_word(
    input logic [ADDR_W-1:0] addr,
    input logic [CFG_W-1:0]  cfg,
    input logic [NUM_IND-1:0] inds,
    input logic [NUM_EVT-1:0] helds
  );
    logic [DATA_W-1:0] w;
    w = '0;
    if (addr == CFG_OFFSET) begin
      w[CFG_W-1:0] = cfg;
      w[RSVD_BIT] = 1'b0;
    end else if (addr == STATUS_OFFSET) begin
      w[STAT_IND_LSB +: NUM_IND]  = inds;
      w[STAT_HELD_LSB +: NUM_EVT] = helds;
    end
    return w;
  endfunction

  // one wait cycle, then the answer for one cycle
  always_comb begin
    cfg_next   = cfg_reg;
    ack_next   = 1'b0;
    rdata_next = rdata_reg;
    if ((avs_read_in || avs_write_in) && !ack_reg) begin
      ack_next   = 1'b1;
      rdata_next = read_word(avs_address_in, cfg_reg, ind, held);
    end
    if (avs_write_in && ack_reg && avs_address_in == CFG_OFFSET) begin
      if (avs_byteenable_in[0]) begin
        cfg_next[7:0] = avs_writedata_in[7:0];
      end
      if (avs_byteenable_in[1]) begin
        cfg_next[15:8] = avs_writedata_in[15:8];
      end
      cfg_next[RSVD_BIT] = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      cfg_reg   <= CFG_RESET;
      ack_reg   <= 1'b0;
      rdata_reg <= '0;
    end else begin
      cfg_reg   <= cfg_next;
      ack_reg   <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  assign avs_readdata_out    = rdata_reg;
  assign avs_waitrequest_out = !ack_reg;

  // ************************************************************
  // field decode
  // ************************************************************
  sil_sel_t         sel [NUM_IND];
  sil_ivl_t         ivl;
  logic             stretch_en;
  logic [CNT_W-1:0] len;

  assign sel[0]     = sil_sel_t'(cfg_reg[SEL_A_LSB +: SEL_W]);
  assign sel[1]     = sil_sel_t'(cfg_reg[SEL_B_LSB +: SEL_W]);
  assign sel[2]     = sil_sel_t'(cfg_reg[SEL_C_LSB +: SEL_W]);
  assign ivl        = sil_ivl_t'(cfg_reg[IVL_LSB +: IVL_W]);
  assign stretch_en = cfg_reg[STRETCH_BIT];

  always_comb begin
    len = CNT_W'(STRETCH_SHORT);
    unique case (ivl)
      IVL_SHORT: len = CNT_W'(STRETCH_SHORT);
      IVL_MID:   len = CNT_W'(STRETCH_MID);
      IVL_LONG:  len = CNT_W'(STRETCH_LONG);
      IVL_RSVD:  len = CNT_W'(STRETCH_SHORT);
    endcase
  end

  // ************************************************************
  // event stretchers
  // ************************************************************
  logic [NUM_EVT-1:0] raw;
  assign raw[EVT_TX]  = tx_in;
  assign raw[EVT_RX]  = rx_in;
  assign raw[EVT_COL] = col_in;
  assign raw[EVT_ACT] = tx_in | rx_in;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_EVT; gi++) begin : g_evt
      sil_stretch u_stretch (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .event_in   (raw[gi]),
        .len_in     (len),
        .held_out   (held[gi])
      );
    end
  endgenerate

  // ************************************************************
  // test blink generators
  // ************************************************************
  logic [CNT_W-1:0] fast_cnt_reg;
  logic [CNT_W-1:0] fast_cnt_next;
  logic [CNT_W-1:0] slow_cnt_reg;
  logic [CNT_W-1:0] slow_cnt_next;

  always_comb begin
    fast_cnt_next   = fast_cnt_reg + CNT_W'(1);
    blink_fast_next = blink_fast_reg;
    slow_cnt_next   = slow_cnt_reg + CNT_W'(1);
    blink_slow_next = blink_slow_reg;
    if (fast_cnt_reg >= CNT_W'(BLINK_FAST - 1)) begin
      fast_cnt_next   = '0;
      blink_fast_next = !blink_fast_reg;
    end
    if (slow_cnt_reg >= CNT_W'(BLINK_SLOW - 1)) begin
      slow_cnt_next   = '0;
      blink_slow_next = !blink_slow_reg;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      fast_cnt_reg   <= '0;
      slow_cnt_reg   <= '0;
      blink_fast_reg <= 1'b0;
      blink_slow_reg <= 1'b0;
    end else begin
      fast_cnt_reg   <= fast_cnt_next;
      slow_cnt_reg   <= slow_cnt_next;
      blink_fast_reg <= blink_fast_next;
      blink_slow_reg <= blink_slow_next;
    end
  end

  // ************************************************************
  // sources and indicator channels
  // ************************************************************
  sil_src_t src;

  always_comb begin
    src.speed      = speed_in;
    src.link       = link_in;
    src.duplex     = duplex_in;
    src.tx         = stretch_en ? held[EVT_TX]  : tx_in;
    src.rx         = stretch_en ? held[EVT_RX]  : rx_in;
    src.col        = stretch_en ? held[EVT_COL] : col_in;
    src.act        = stretch_en ? held[EVT_ACT] : raw[EVT_ACT];
    src.rx_held    = held[EVT_RX];
    src.act_held   = held[EVT_ACT];
    src.col_held   = held[EVT_COL];
    src.blink_fast = blink_fast_reg;
    src.blink_slow = blink_slow_reg;
  end

  generate
    for (gi = 0; gi < NUM_IND; gi++) begin : g_ind
      sil_channel u_channel (
        .sys_clk_in (sys_clk_in),
        .rst_in     (rst_in),
        .sel_in     (sel[gi]),
        .src_in     (src),
        .ind_out    (ind[gi])
      );
    end
  endgenerate

  assign indicator_out = ind;

  // ************************************************************
  // assertions
  // ************************************************************
  property p_reset_a;
    @(posedge sys_clk_in) rst_in |=> cfg_reg[SEL_A_LSB +: SEL_W] == 4'h0;
  endproperty
  a_reset_a: assert property (p_reset_a) else $error("bad A reset");

  property p_speed_a;
    @(posedge sys_clk_in) disable iff (rst_in)
      sel[0] == SEL_SPEED |=> indicator_out[0] == $past(speed_in);
  endproperty
  a_speed_a: assert property (p_speed_a) else $error("A not speed");

  property p_tx_raw;
    @(posedge sys_clk_in) disable iff (rst_in)
      (sel[1] == SEL_TX && !stretch_en) |=> indicator_out[1] == $past(tx_in);
  endproperty
  a_tx_raw: assert property (p_tx_raw) else $error("B not raw tx");

  property p_link_b;
    @(posedge sys_clk_in) disable iff (rst_in)
      sel[1] == SEL_LINK |=> indicator_out[1] == $past(link_in);
  endproperty
  a_link_b: assert property (p_link_b) else $error("B not link");

  property p_force;
    @(posedge sys_clk_in) disable iff (rst_in)
      (sel[2] == SEL_ON |=> indicator_out[2]) and
      (sel[2] == SEL_OFF |=> !indicator_out[2]);
  endproperty
  a_force: assert property (p_force) else $error("C not forced");

  property p_unused;
    @(posedge sys_clk_in) disable iff (rst_in)
      (sel[0] == SEL_UNUSED_F || sel[0] == SEL_UNUSED_6) |=> !indicator_out[0];
  endproperty
  a_unused: assert property (p_unused) else $error("unused code lit");

  property p_link_solid;
    @(posedge sys_clk_in) disable iff (rst_in)
      (sel[0] == SEL_LINK_ACT && link_in && !held[EVT_ACT])
        |=> indicator_out[0];
  endproperty
  a_link_solid: assert property (p_link_solid) else $error("link not solid");

  property p_dup_col;
    @(posedge sys_clk_in) disable iff (rst_in)
      (sel[2] == SEL_DUP_COL && duplex_in && held[EVT_COL])
        |=> !indicator_out[2];
  endproperty
  a_dup_col: assert property (p_dup_col) else $error("collision no blink");

  sequence s_rx_pulse_nolink;
    (sel[0] == SEL_LINK_RX && !stretch_en && !link_in && rx_in)
      ##1 (sel[0] == SEL_LINK_RX && !link_in && !rx_in)[*2];
  endsequence
  property p_combined_stretch;
    @(posedge sys_clk_in) disable iff (rst_in)
      s_rx_pulse_nolink |-> indicator_out[0];
  endproperty
  a_combined_stretch: assert property (p_combined_stretch) else $error("combined unstretched");

  property p_reset_bc;
    @(posedge sys_clk_in)
      rst_in |=> cfg_reg[SEL_B_LSB +: SEL_W] == 4'h4 &&
                 cfg_reg[SEL_C_LSB +: SEL_W] == 4'h2;
  endproperty
  a_reset_bc: assert property (p_reset_bc) else $error("bad B/C reset");

  property p_reset_stretch;
    @(posedge sys_clk_in)
      rst_in |=> stretch_en && cfg_reg[IVL_LSB +: IVL_W] == 2'h0;
  endproperty
  a_reset_stretch: assert property (p_reset_stretch) else $error("bad stretch reset");

  property p_rsvd_zero;
    @(posedge sys_clk_in) disable iff (rst_in)
      (ack_reg && avs_read_in && avs_address_in == CFG_OFFSET)
        |-> avs_readdata_out[RSVD_BIT] == 1'b0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bit set");

  property p_rx_c;
    @(posedge sys_clk_in) disable iff (rst_in)
      (sel[2] == SEL_RX && stretch_en && rx_in) ##1 sel[2] == SEL_RX
        |=> indicator_out[2];
  endproperty
  a_rx_c: assert property (p_rx_c) else $error("rx not stretched");

  property p_ack_once;
    @(posedge sys_clk_in) disable iff (rst_in)
      ack_reg |=> !ack_reg;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("answer too long");

endmodule

// [sil_top_tb.sv]
// self-checking bench for the status indicator block
// assumes sil_top with short stretch and blink counts
`timescale 1ns/1ps

module sil_top_tb;
  import sil_pkg::*;

  // ************************************************************
  // signals and instances
  // ************************************************************
  logic              sys_clk_in = 1'b0;
  logic              rst_in     = 1'b1;
  logic [ADDR_W-1:0] avs_address   = '0;
  logic              avs_read      = 1'b0;
  logic              avs_write     = 1'b0;
  logic [DATA_W-1:0] avs_writedata = '0;
  logic [3:0]        avs_be        = 4'hF;
  logic [DATA_W-1:0] avs_readdata;
  logic              avs_waitrequest;
  logic              spd = 1'b0, lnk = 1'b0, dup = 1'b0;
  logic [2:0]        evt = 3'h0;
  logic [2:0]        ind;
  logic [2:0][7:0]   lit;
  logic              clear = 1'b0;
  logic [31:0]       rdata;
  int                num_errors   = 0;
  int                total_checks = 0;

  always #10 sys_clk_in = ~sys_clk_in;

  sil_top #(.STRETCH_SHORT(8), .STRETCH_MID(12), .STRETCH_LONG(16),
            .BLINK_FAST(4), .BLINK_SLOW(10)) sil_top_i (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in),
    .avs_address_in(avs_address), .avs_read_in(avs_read),
    .avs_write_in(avs_write), .avs_writedata_in(avs_writedata),
    .avs_byteenable_in(avs_be), .avs_readdata_out(avs_readdata),
    .avs_waitrequest_out(avs_waitrequest), .speed_in(spd),
    .link_in(lnk), .duplex_in(dup), .tx_in(evt[0]), .rx_in(evt[1]),
    .col_in(evt[2]), .indicator_out(ind));

  sil_led_model sil_led_model_i (
    .sys_clk_in(sys_clk_in), .clear_in(clear), .ind_in(ind),
    .lit_out(lit));

  // ************************************************************
  // shared tasks
  // ************************************************************
  task report_and_stop;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one bus cycle, held until waitrequest is sampled low
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk_in);
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= d;
    n = 0;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rdata = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      num_errors++;
      report_and_stop();
    end
  endtask

  task rd(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rdata, exp);
  endtask

  // same code on all three indicators; bit 0 written as zero
  task wr_cfg(input logic [3:0] s, input logic [1:0] ivl, input logic st);
    bus(1'b1, CFG_OFFSET, {16'h0, s, s, s, ivl, st, 1'b0});
  endtask

  task set_lvl(input logic s, input logic l, input logic d);
    @(posedge sys_clk_in);
    spd <= s;
    lnk <= l;
    dup <= d;
  endtask

  task chk_ind(input logic [2:0] exp);
    repeat (3) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    chk({29'h0, ind}, {29'h0, exp});
  endtask

  function automatic logic exp_lvl(input logic [3:0] c, input logic s,
                                   input logic l, input logic d);
    case (c)
      4'h0: return s;
      4'h4, 4'hC, 4'hD: return l;
      4'h5, 4'hE: return d;
      4'h8: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // ************************************************************
  // scenarios
  // ************************************************************
  task t_reset;
    rd(CFG_OFFSET, 32'h0000_0422);
    bus(1'b1, 8'h40, 32'h0000_FFFC);
    rd(8'h40, 32'h0);
    rd(CFG_OFFSET, 32'h0000_0422);
    set_lvl(1'b1, 1'b0, 1'b0);
    chk_ind(3'h1);
    set_lvl(1'b0, 1'b1, 1'b0);
    chk_ind(3'h2);
    rd(STATUS_OFFSET, 32'h0000_0002);
    // upper lane only: low byte of the config must stay
    avs_be <= 4'h2;
    bus(1'b1, CFG_OFFSET, 32'h0000_9998);
    avs_be <= 4'hF;
    rd(CFG_OFFSET, 32'h0000_9922);
  endtask

  task t_levels;
    logic s, l, d;
    for (int c = 0; c < 16; c++) begin
      if (c != 10 && c != 11) begin
        wr_cfg(c[3:0], 2'h0, 1'b1);
        for (int p = 0; p < 2; p++) begin
          s = p[0];
          l = !p[0];
          d = p[0];
          set_lvl(s, l, d);
          chk_ind({3{exp_lvl(c[3:0], s, l, d)}});
        end
      end
    end
    set_lvl(1'b0, 1'b0, 1'b0);
  endtask

  // one or two event pulses, then count lit cycles of each indicator
  task t_event(input logic [3:0] c, input logic [2:0] m,
               input logic [1:0] ivl, input logic st, input int gap,
               input logic [7:0] exp);
    wr_cfg(c, ivl, st);
    @(posedge sys_clk_in);
    clear <= 1'b1;
    evt   <= m;
    @(posedge sys_clk_in);
    clear <= 1'b0;
    evt   <= 3'h0;
    if (gap > 1) begin
      repeat (gap - 1) @(posedge sys_clk_in);
      evt <= m;
      @(posedge sys_clk_in);
      evt <= 3'h0;
    end
    repeat (30) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    for (int i = 0; i < 3; i++) begin
      chk({24'h0, lit[i]}, {24'h0, exp});
    end
  endtask

  task t_blink(input logic [3:0] c);
    wr_cfg(c, 2'h0, 1'b1);
    repeat (10) @(posedge sys_clk_in);
    clear <= 1'b1;
    @(posedge sys_clk_in);
    clear <= 1'b0;
    repeat (40) @(posedge sys_clk_in);
    @(negedge sys_clk_in);
    for (int i = 0; i < 3; i++) begin
      chk({24'h0, lit[i]}, 32'd20);
    end
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    repeat (12) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    t_reset();
    t_levels();
    t_event(4'h1, 3'h1, 2'h0, 1'b0, 0, 8'd1);
    t_event(4'h2, 3'h2, 2'h0, 1'b0, 0, 8'd1);
    t_event(4'h3, 3'h4, 2'h0, 1'b0, 0, 8'd1);
    t_event(4'h7, 3'h2, 2'h0, 1'b0, 0, 8'd1);
    t_event(4'h2, 3'h2, 2'h0, 1'b1, 0, 8'd8);
    t_event(4'h2, 3'h2, 2'h1, 1'b1, 0, 8'd12);
    t_event(4'h2, 3'h2, 2'h2, 1'b1, 0, 8'd16);
    t_event(4'h2, 3'h2, 2'h3, 1'b1, 0, 8'd8);
    t_event(4'h7, 3'h1, 2'h1, 1'b1, 0, 8'd12);
    t_event(4'h3, 3'h4, 2'h0, 1'b1, 0, 8'd8);
    t_event(4'h1, 3'h1, 2'h0, 1'b1, 4, 8'd12);
    t_event(4'hC, 3'h2, 2'h0, 1'b0, 0, 8'd8);
    t_event(4'hD, 3'h1, 2'h1, 1'b0, 0, 8'd12);
    t_event(4'hE, 3'h4, 2'h2, 1'b0, 0, 8'd16);
    t_blink(4'hA);
    t_blink(4'hB);
    report_and_stop();
  end
endmodule
